// ===== hw/fvh_slave.sv
`timescale 1ns/10ps
`default_nettype none
module fvh_slave
    import fvh_pkg::*;
#(
    parameter int KEY_HOLD = KEY_HOLD_CYC, // key hold cycles
    parameter int REDUCE   = REDUCE_CYC,   // power reduction delay
    parameter int WDOG     = WDOG_CYC,     // bus watchdog cycles
    parameter int TRAVEL   = TRAVEL_CYC    // max travel wait
)(
    input  wire logic        clk_sys,            // system clock
    input  wire logic        reset,              // async reset, high
    input  wire logic [3:0]  out_data,           // master output bits
    input  wire logic        out_strobe,         // out_data valid pulse
    input  wire logic [3:0]  par_data,           // parameter bits
    input  wire logic        par_strobe,         // par_data valid pulse
    input  wire logic        sens_top,           // top reached
    input  wire logic        sens_bot,           // bottom reached
    input  wire logic        puck_present,       // target detected
    input  wire logic        teach_key,          // local key, high=pressed
    input  wire logic        no_pilot,           // variant strap
    input  wire logic        ab_mode,            // a/b addressing select
    input  wire logic        jmp_swap,           // lamp colour jumper
    output logic [3:0]       in_data,            // bits to master
    output logic             valve_drive_output, // valve coil on
    output logic             valve_reduced,      // reduced power level
    output logic             teach_active,       // teach running
    output fvh_pkg::fvh_ident_t ident,           // profile identity
    output fvh_pkg::fvh_leds_t  leds             // indicators
);
    import fvh_pkg::*;

    typedef struct packed {
        fvh_teach_t  tst;
        logic        bus_valve;
        logic        par_teach;
        logic        rec_top;
        logic        rec_bot;
        logic        key_prev;
        logic [CNT_W-1:0] blink;
        logic [3:0]  in_data;
        logic        valve;
        logic        reduced;
        fvh_ident_t  ident;
        fvh_leds_t   leds;
    } fvh_state_t;

    fvh_state_t st_ff;
    fvh_state_t nxt_st;
    logic       key_done;
    logic       red_done;
    logic       wd_done;
    logic       trv_done;
    logic       wd_run;
    logic       trv_run;

    fvh_timer u_key (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (teach_key),
        .limit   (CNT_W'(KEY_HOLD)),
        .done    (key_done)
    );

    fvh_timer u_red (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (st_ff.valve),
        .limit   (CNT_W'(REDUCE)),
        .done    (red_done)
    );

    // bus watchdog: restarts on each output update
    assign wd_run = !out_strobe;
    fvh_timer u_wd (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (wd_run),
        .limit   (CNT_W'(WDOG)),
        .done    (wd_done)
    );

    assign trv_run = (st_ff.tst == FVH_RISE) || (st_ff.tst == FVH_FALL);
    fvh_timer u_trv (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (trv_run),
        .limit   (CNT_W'(TRAVEL)),
        .done    (trv_done)
    );

    // one start per press: only the first cycle of a full hold counts
    logic key_start;
    assign key_start = key_done && !st_ff.key_prev;

    always_comb begin
        logic p0_fall;
        logic p0_rise;
        logic teach_on;
        logic top_pos;
        logic bot_pos;
        p0_fall  = 1'b0;
        p0_rise  = 1'b0;
        teach_on = 1'b0;
        top_pos  = 1'b0;
        bot_pos  = 1'b0;
        nxt_st   = st_ff;
        nxt_st.blink = st_ff.blink + 1'b1;
        nxt_st.key_prev = key_done;

        // only a change of p0 acts; a repeated level is ignored
        if (par_strobe) begin
            nxt_st.par_teach = par_data[PAR_TEACH_BIT];
            p0_fall = st_ff.par_teach && !par_data[PAR_TEACH_BIT];
            p0_rise = !st_ff.par_teach && par_data[PAR_TEACH_BIT];
        end

        // bus commands are dropped, not queued, while teach runs
        if (out_strobe && st_ff.tst == FVH_IDLE) begin
            nxt_st.bus_valve = out_data[OUT_VALVE_BIT];
        end
        // teach sequence
        case (st_ff.tst)
            FVH_IDLE: begin
                if (p0_fall || key_start) begin
                    nxt_st.tst       = FVH_REC_BOT;
                    // stale bus command must not reopen the valve later
                    nxt_st.bus_valve = 1'b0;
                end
            end
            FVH_REC_BOT: begin
                nxt_st.rec_bot = sens_bot;
                nxt_st.tst     = FVH_RISE;
            end
            // travel timeout keeps a stuck actuator from hanging teach
            FVH_RISE: begin
                if (sens_top || trv_done) begin
                    nxt_st.tst = FVH_REC_TOP;
                end
            end
            FVH_REC_TOP: begin
                nxt_st.rec_top = sens_top;
                nxt_st.tst     = FVH_FALL;
            end
            FVH_FALL: begin
                if (sens_bot || trv_done) begin
                    nxt_st.tst = FVH_IDLE;
                end
            end
            default: nxt_st.tst = FVH_IDLE;
        endcase

        // stop request wins over any teach phase
        if (p0_rise) begin
            nxt_st.tst = FVH_IDLE;
        end
        teach_on = (st_ff.tst != FVH_IDLE);
        top_pos  = sens_top && puck_present;
        bot_pos  = sens_bot && puck_present;

        // positions only count while the puck is seen
        nxt_st.in_data = '0;
        nxt_st.in_data[IN_TOP_BIT] = top_pos;
        nxt_st.in_data[IN_BOT_BIT] = bot_pos;
        // valve on during rise phase of teach unless no_pilot, else from bus
        if (teach_on) begin
            nxt_st.valve = (st_ff.tst == FVH_RISE) && !no_pilot;
        end else begin
            // watchdog drops the coil until a fresh update arrives
            nxt_st.valve = st_ff.bus_valve && !wd_done;
        end
        // falls one cycle after the coil so each switch-on starts at full power
        nxt_st.reduced = st_ff.valve && red_done;

        nxt_st.ident.io_cfg = IO_CFG_ID;
        if (ab_mode) begin
            nxt_st.ident.id_code = ID_AB;
            nxt_st.ident.xid1    = XID1_AB;
            nxt_st.ident.xid2    = XID2_AB;
        end else begin
            nxt_st.ident.id_code = ID_STD;
            nxt_st.ident.xid1    = XID1_STD;
            nxt_st.ident.xid2    = XID2_STD;
        end
        if (teach_on && no_pilot) begin
            nxt_st.leds.valve_ind = (st_ff.tst == FVH_RISE);
        end else begin
            nxt_st.leds.valve_ind = nxt_st.valve;
        end

        // flash during teach wins over the puck flicker
        if (teach_on) begin
            nxt_st.leds.status_ind = st_ff.blink[FLASH_BIT];
        end else if (!puck_present) begin
            nxt_st.leds.status_ind = st_ff.blink[FLICKER_BIT];
        end else begin
            nxt_st.leds.status_ind = 1'b0;
        end

        if (jmp_swap) begin
            nxt_st.leds.top_green  = top_pos;
            nxt_st.leds.top_yellow = bot_pos;
        end else begin
            nxt_st.leds.top_green  = bot_pos;
            nxt_st.leds.top_yellow = top_pos;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_ff           <= '0;
            st_ff.tst       <= FVH_IDLE;
            st_ff.par_teach <= PAR_RESET[PAR_TEACH_BIT];
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign in_data            = st_ff.in_data;
    assign valve_drive_output = st_ff.valve;
    assign valve_reduced      = st_ff.reduced;
    assign teach_active       = (st_ff.tst != FVH_IDLE);
    assign ident              = st_ff.ident;
    assign leds               = st_ff.leds;
endmodule
`default_nettype wire

// ===== hw/fvh_pkg.sv
// Overview of operation
// - input bit d3 reports top end position
// - input bit d2 reports bottom end position
// - key held five seconds starts teach
// - bus valve commands ignored during teach
// - valve power reduced 100 ms after on
// - no-pilot variant: indicator requests manual moves
// - standard and a/b profile identities selectable
// - top lamp colour chosen by jumper
// - teach: bottom, valve on, top, off
// - status indicator flashes while teaching
// - status indicator flickers when puck missing
package fvh_pkg;
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          KEY_HOLD_MS    = 5000;
    localparam int          REDUCE_MS      = 100;
    localparam int          KEY_HOLD_CYC   = CLK_HZ / 1000 * KEY_HOLD_MS;
    localparam int          REDUCE_CYC     = CLK_HZ / 1000 * REDUCE_MS;
    localparam int          WDOG_CYC       = CLK_HZ / 1000 * REDUCE_MS;
    localparam int          TRAVEL_CYC     = CLK_HZ / 1000 * KEY_HOLD_MS;
    localparam int          FLASH_BIT      = 24;
    localparam int          FLICKER_BIT    = 21;
    localparam int          CNT_W          = 32;
    localparam int          IN_TOP_BIT     = 3;
    localparam int          IN_BOT_BIT     = 2;
    localparam int          OUT_VALVE_BIT  = 0;
    localparam int          PAR_TEACH_BIT  = 0;
    localparam logic [3:0]  PAR_RESET      = 4'hf;
    // identity codes: arbitrary neutral values
    localparam logic [3:0]  IO_CFG_ID      = 4'h1;
    localparam logic [3:0]  ID_STD         = 4'h2;
    localparam logic [3:0]  ID_AB          = 4'h3;
    localparam logic [3:0]  XID1_STD       = 4'h4;
    localparam logic [3:0]  XID1_AB        = 4'h5;
    localparam logic [3:0]  XID2_STD       = 4'h6;
    localparam logic [3:0]  XID2_AB        = 4'h8;

    typedef enum logic [2:0] {
        FVH_IDLE, FVH_REC_BOT, FVH_RISE, FVH_REC_TOP, FVH_FALL
    } fvh_teach_t;

    typedef struct packed {
        logic [3:0] io_cfg;
        logic [3:0] id_code;
        logic [3:0] xid1;
        logic [3:0] xid2;
    } fvh_ident_t;

    typedef struct packed {
        logic valve_ind;
        logic status_ind;
        logic top_green;
        logic top_yellow;
    } fvh_leds_t;
endpackage

// ===== hw/fvh_timer.sv
`timescale 1ns/10ps
`default_nettype none
// counts while run is high, done once count reaches limit
module fvh_timer
    import fvh_pkg::*;
(
    input  wire logic              clk_sys, // system clock
    input  wire logic              reset,   // async reset
    input  wire logic              run,     // count enable level
    input  wire logic [CNT_W-1:0]  limit,   // terminal count
    output logic                   done     // limit reached, level
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } fvh_tmr_t;

    fvh_tmr_t st_ff;
    fvh_tmr_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!run) begin
            nxt_st.cnt  = '0;
            nxt_st.done = 1'b0;
        end else if (st_ff.cnt >= limit - 1) begin
            nxt_st.done = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done = st_ff.done;
endmodule
`default_nettype wire

// ===== bench/fvh_slave_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module fvh_slave_asserts
    import fvh_pkg::*;
#(
    parameter int KEY_HOLD = 20, // key hold cycles
    parameter int REDUCE   = 20  // reduction delay
)(
    input wire logic                clk_sys,            // clock
    input wire logic                reset,              // reset
    input wire logic [3:0]          out_data,           // bus out
    input wire logic                out_strobe,         // out valid
    input wire logic [3:0]          par_data,           // param
    input wire logic                par_strobe,         // param valid
    input wire logic                sens_top,           // top
    input wire logic                sens_bot,           // bottom
    input wire logic                puck_present,       // puck
    input wire logic                teach_key,          // key
    input wire logic                ab_mode,            // a/b select
    input wire logic [3:0]          in_data,            // bus in
    input wire logic                valve_drive_output, // valve
    input wire logic                valve_reduced,      // reduced
    input wire logic                teach_active,       // teaching
    input wire fvh_pkg::fvh_ident_t ident,              // identity
    input wire fvh_pkg::fvh_leds_t  leds                // indicators
);
    logic [CNT_W-1:0] on_cnt_ff;
    logic [CNT_W-1:0] key_cnt_ff;
    logic             p0_ff;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            on_cnt_ff  <= 32'h0;
            key_cnt_ff <= 32'h0;
            p0_ff      <= 1'b1;
        end else begin
            on_cnt_ff  <= valve_drive_output ? on_cnt_ff + 1 : 32'h0;
            key_cnt_ff <= teach_key ? key_cnt_ff + 1 : 32'h0;
            if (par_strobe) p0_ff <= par_data[0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_cmd;
        out_strobe && !teach_active ##1 !teach_active;
    endsequence
    top_bit_a:
    assert property (!$past(reset) |->
        in_data[3] == $past(sens_top && puck_present))
        else $error("top bit wrong");
    bot_bit_a:
    assert property (!$past(reset) |->
        in_data[2:0] == {$past(sens_bot && puck_present), 2'b00})
        else $error("bottom bit wrong");
    valve_cmd_a:
    assert property (s_cmd |=>
        valve_drive_output == $past(out_data[0], 2))
        else $error("valve does not follow command");
    power_cut_a:
    assert property (on_cnt_ff > REDUCE + 2 |-> valve_reduced)
        else $error("power not reduced");
    teach_go_a:
    assert property (par_strobe && !par_data[0] && p0_ff
        |-> ##[1:2] teach_active) else $error("teach not started");
    teach_halt_a:
    assert property (par_strobe && par_data[0] && !p0_ff && teach_active
        |-> ##[1:2] !teach_active) else $error("teach not stopped");
    key_start_a:
    assert property (key_cnt_ff == KEY_HOLD + 3 |-> teach_active)
        else $error("key hold ignored");
    profile_id_a:
    assert property (!$past(reset) |->
        ident.id_code == ($past(ab_mode) ? ID_AB : ID_STD))
        else $error("identity wrong");
    status_quiet_a:
    assert property (!$past(teach_active) && $past(puck_present)
        |-> !leds.status_ind)
        else $error("status indicator lit while idle");
endmodule
`default_nettype wire

// ===== bench/fvh_master.sv
`timescale 1ns/10ps
`default_nettype none
module fvh_master (
    input  wire logic       clk_sys,            // clock
    input  wire logic       valve_drive_output, // valve
    output logic [3:0]      out_data,           // bus out
    output logic            out_strobe,         // out valid
    output logic [3:0]      par_data,           // param
    output logic            par_strobe,         // param valid
    output logic            sens_top,           // top
    output logic            sens_bot            // bottom
);
    logic [2:0] pos;
    initial begin
        out_data   = 4'h0;
        out_strobe = 1'b0;
        par_data   = 4'hf;
        par_strobe = 1'b0;
        pos        = 3'h0;
    end
    // actuator travels one step a cycle
    always @(negedge clk_sys) begin
        if (valve_drive_output && pos < 3'h6) pos <= pos + 3'h1;
        else if (!valve_drive_output && pos != 3'h0) pos <= pos - 3'h1;
    end
    assign sens_top = (pos == 3'h6);
    assign sens_bot = (pos == 3'h0);
    // upper bits set: must be ignored
    task automatic send_valve(input logic v);
        @(negedge clk_sys);
        out_data   = {3'h5, v};
        out_strobe = 1'b1;
        @(negedge clk_sys);
        out_strobe = 1'b0;
    endtask
    task automatic send_par(input logic v);
        @(negedge clk_sys);
        par_data   = {3'h5, v};
        par_strobe = 1'b1;
        @(negedge clk_sys);
        par_strobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import fvh_pkg::*;
    localparam int KEY_HOLD = 20;
    localparam int REDUCE   = 20;
    localparam int WDOG     = 200;
    logic       clk_sys, reset, puck_present, teach_key;
    logic       no_pilot, ab_mode, jmp_swap, seen_on;
    logic [3:0] out_data, par_data, in_data;
    logic       out_strobe, par_strobe, sens_top, sens_bot;
    logic       valve_drive_output, valve_reduced, teach_active;
    fvh_ident_t ident;
    fvh_leds_t  leds;
    int         fails, comparisons, k;
    fvh_slave #(.KEY_HOLD(KEY_HOLD), .REDUCE(REDUCE), .WDOG(WDOG),
        .TRAVEL(30)) fvh_slave_i (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .out_data           (out_data),
        .out_strobe         (out_strobe),
        .par_data           (par_data),
        .par_strobe         (par_strobe),
        .sens_top           (sens_top),
        .sens_bot           (sens_bot),
        .puck_present       (puck_present),
        .teach_key          (teach_key),
        .no_pilot           (no_pilot),
        .ab_mode            (ab_mode),
        .jmp_swap           (jmp_swap),
        .in_data            (in_data),
        .valve_drive_output (valve_drive_output),
        .valve_reduced      (valve_reduced),
        .teach_active       (teach_active),
        .ident              (ident),
        .leds               (leds)
    );
    fvh_master fvh_master_i (
        .clk_sys            (clk_sys),
        .valve_drive_output (valve_drive_output),
        .out_data           (out_data),
        .out_strobe         (out_strobe),
        .par_data           (par_data),
        .par_strobe         (par_strobe),
        .sens_top           (sens_top),
        .sens_bot           (sens_bot)
    );
    always #5 clk_sys = ~clk_sys;
    task automatic check(input string n, input logic [3:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wait_teach(input logic v);
        for (k = 0; k < 200 && teach_active !== v; k++) cyc(1);
        if (k == 200) begin
            fails++;
            conclude();
        end
    endtask
    initial begin
        {clk_sys, reset, puck_present} = 3'h7;
        {teach_key, no_pilot, ab_mode, jmp_swap} = 4'h0;
        {fails, comparisons} = 0;
        cyc(16);
        reset = 1'b0;
        cyc(3);
        for (int m = 0; m < 2; m++) begin
            ab_mode = m[0];
            cyc(2);
            check("id", ident.id_code, m ? ID_AB : ID_STD);
            check("xid2", ident.xid2, m ? XID2_AB : XID2_STD);
            check("xid1", ident.xid1, m ? XID1_AB : XID1_STD);
            check("io_cfg", ident.io_cfg, IO_CFG_ID);
        end
        check("bottom", in_data, 4'h4);
        for (int j = 0; j < 2; j++) begin
            jmp_swap = j[0];
            cyc(2);
            check("lamps", {leds.top_green, leds.top_yellow},
                j ? 4'h1 : 4'h2);
        end
        puck_present = 1'b0;
        cyc(2);
        check("no_puck", in_data, 4'h0);
        puck_present = 1'b1;
        $display("test positions done");
        fvh_master_i.send_valve(1'b1);
        cyc(12);
        check("top", in_data, 4'h8);
        check("early", valve_reduced, 1'b0);
        cyc(REDUCE);
        check("reduced", {valve_reduced, valve_drive_output}, 3);
        fvh_master_i.send_valve(1'b0);
        cyc(12);
        check("off", {valve_reduced, valve_drive_output}, 0);
        fvh_master_i.send_valve(1'b1);
        cyc(WDOG + 10);
        check("watchdog", valve_drive_output, 1'b0);
        fvh_master_i.send_valve(1'b0);
        cyc(10);
        $display("test valve done");
        fvh_master_i.send_par(1'b0);
        wait_teach(1'b1);
        seen_on = 1'b0;
        for (k = 0; k < 200 && teach_active; k++) begin
            cyc(1);
            seen_on |= valve_drive_output;
        end
        check("cycle", {seen_on, teach_active, in_data[2]}, 5);
        fvh_master_i.send_par(1'b0);
        cyc(4);
        check("level", teach_active, 1'b0);
        fvh_master_i.send_par(1'b1);
        fvh_master_i.send_par(1'b0);
        wait_teach(1'b1);
        fvh_master_i.send_valve(1'b1);
        fvh_master_i.send_par(1'b1);
        cyc(4);
        check("locked", {teach_active, valve_drive_output}, 0);
        fvh_master_i.send_valve(1'b0);
        cyc(10);
        $display("test teach done");
        teach_key = 1'b1;
        cyc(KEY_HOLD - 4);
        teach_key = 1'b0;
        cyc(3);
        check("short_key", teach_active, 1'b0);
        teach_key = 1'b1;
        cyc(KEY_HOLD + 4);
        check("long_key", teach_active, 1'b1);
        teach_key = 1'b0;
        wait_teach(1'b0);
        no_pilot = 1'b1;
        fvh_master_i.send_par(1'b0);
        wait_teach(1'b1);
        cyc(4);
        check("manual", {leds.valve_ind, valve_drive_output}, 2);
        fvh_master_i.send_par(1'b1);
        wait_teach(1'b0);
        $display("test key and variant done");
        conclude();
    end
endmodule
bind fvh_slave fvh_slave_asserts #(.KEY_HOLD(KEY_HOLD), .REDUCE(REDUCE))
    fvh_slave_asserts_i (
    .clk_sys            (clk_sys),
    .reset              (reset),
    .out_data           (out_data),
    .out_strobe         (out_strobe),
    .par_data           (par_data),
    .par_strobe         (par_strobe),
    .sens_top           (sens_top),
    .sens_bot           (sens_bot),
    .puck_present       (puck_present),
    .teach_key          (teach_key),
    .ab_mode            (ab_mode),
    .in_data            (in_data),
    .valve_drive_output (valve_drive_output),
    .valve_reduced      (valve_reduced),
    .teach_active       (teach_active),
    .ident              (ident),
    .leds               (leds)
);
`default_nettype wire
